// ### hdl/diag_prom_consts.svh
// constants for the diagnostic registered prom block
`ifndef DIAG_PROM_CONSTS_SVH
`define DIAG_PROM_CONSTS_SVH
`define DP_ADDR_W       12
`define DP_DATA_W       4
`define DP_DEPTH        4096
`define DP_SYNC_STAGES  2
`define DP_BUF_DEPTH    2
`define DP_CLK_IDLE     1'b1
`define DP_CTRL_IDLE    1'b0
`define DP_OEN_IDLE     1'b1
`endif

// ### hdl/diag_prom_pkg.sv
// types shared by the diagnostic registered prom block
package diag_prom_pkg;
  // shadow register operation chosen on a diagnostic clock edge
  typedef enum logic [1:0]
  {
    SH_SHIFT = 2'b00,
    SH_LOAD  = 2'b01,
    SH_HOLD  = 2'b10
  } shadow_op_t;
endpackage : diag_prom_pkg

// ### hdl/word_buffer.sv
// two-entry valid/ready buffer for output register words
`timescale 1ns/10ps
module word_buffer #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];   // storage entries
  logic [PW-1:0]    wp_r;            // write pointer
  logic [PW-1:0]    rp_r;            // read pointer
  logic [PW:0]      cnt_r;           // words held
  wire              push;            // accepted write
  wire              pop;             // accepted read

  assign in_ready  = (cnt_r != DEPTH[PW:0]);
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rp_r];

  // pointer wrap helper
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  // pointers and occupancy
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= bump(wp_r);
      if (pop)
        rp_r <= bump(rp_r);
      cnt_r <= cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  // data storage, no reset needed
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
endmodule : word_buffer

// ### hdl/diag_prom.sv
// registered prom with shadow scan register, sampled pin clocks
`timescale 1ns/10ps
`include "diag_prom_consts.svh"
// Overview of operation
// - output register loads on main clock rise when the buffer has room
// - shadow register changes on diagnostic clock rise
// - mode low: load array word, shadow shifts
// - mode high: output register takes shadow
// - mode high, scan_in low: shadow loads bus
// - mode high, scan_in high: shadow holds
// - shift toward msb, scan_in into lsb
// - mode low: scan_out shows shadow msb
// - mode high: scan_out follows scan_in
// - parallel load takes register or pin levels
// - active-low enable drives or floats pins
// - mode low, both clocks together: load and shift
// - register without clock edge holds contents
module diag_prom #(
  parameter int ADDR_W = `DP_ADDR_W,
  parameter int DATA_W = `DP_DATA_W,
  parameter int DEPTH  = `DP_DEPTH,
  parameter logic [DEPTH*DATA_W-1:0] CONTENTS = '0
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              main_clock,
  input  wire logic              diag_clock,
  input  wire logic              mode_sel,
  input  wire logic              scan_in,
  output logic                   scan_out,
  input  wire logic [ADDR_W-1:0] prom_address,
  input  wire logic              out_enable_n,
  input  wire logic [DATA_W-1:0] data_out_bus_in,
  output logic      [DATA_W-1:0] data_out_bus_out,
  output logic      [DATA_W-1:0] data_out_bus_oe_n,
  output logic                   word_valid,
  input  wire logic              word_ready,
  output logic      [DATA_W-1:0] word_data
);
  // two-stage synchronisers for every pin input
  logic              mclk_s1_r;     // main clock, first stage
  logic              mclk_s2_r;     // main clock, second stage
  logic              mclk_d_r;      // main clock, edge delay
  logic              dg_s1_r;       // diagnostic clock, first stage
  logic              dg_s2_r;       // diagnostic clock, second stage
  logic              dg_d_r;        // diagnostic clock, edge delay
  logic              mode_s1_r;     // mode select, first stage
  logic              mode_s2_r;     // mode select, second stage
  logic              sin_s1_r;      // serial input, first stage
  logic              sin_s2_r;      // serial input, second stage
  logic              oen_s1_r;      // output enable, first stage
  logic              oen_s2_r;      // output enable, second stage
  logic [ADDR_W-1:0] adr_s1_r;      // address, first stage
  logic [ADDR_W-1:0] adr_s2_r;      // address, second stage
  logic [DATA_W-1:0] bus_s1_r;      // data pin levels, first stage
  logic [DATA_W-1:0] bus_s2_r;      // data pin levels, second stage
  logic [DATA_W-1:0] out_reg_r;      // output register, no reset
  logic [DATA_W-1:0] shadow_bits;    // shadow register, no reset
  logic              buf_ready;      // buffer room for a new word

  // table of programmed words, fixed at build time
  function automatic logic [DATA_W-1:0] rom_word(
    input logic [ADDR_W-1:0] a);
    rom_word = CONTENTS[a*DATA_W +: DATA_W];
  endfunction : rom_word

  // main clock pin: two stages, then a delay stage for edge detection;
  // reset to the high level so a pin that idles high gives no false edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mclk_s1_r <= `DP_CLK_IDLE;
      mclk_s2_r <= `DP_CLK_IDLE;
      mclk_d_r  <= `DP_CLK_IDLE;
    end
    else
    begin
      mclk_s1_r <= main_clock;
      mclk_s2_r <= mclk_s1_r;      // first stage read only here
      mclk_d_r  <= mclk_s2_r;
    end
  end

  // diagnostic clock pin: same two stages and delay as the main clock
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dg_s1_r <= `DP_CLK_IDLE;
      dg_s2_r <= `DP_CLK_IDLE;
      dg_d_r  <= `DP_CLK_IDLE;
    end
    else
    begin
      dg_s1_r <= diag_clock;
      dg_s2_r <= dg_s1_r;          // first stage read only here
      dg_d_r  <= dg_s2_r;
    end
  end

  // mode select and serial input, sampled before any decode reads them
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_s1_r <= `DP_CTRL_IDLE;
      mode_s2_r <= `DP_CTRL_IDLE;
      sin_s1_r  <= `DP_CTRL_IDLE;
      sin_s2_r  <= `DP_CTRL_IDLE;
    end
    else
    begin
      mode_s1_r <= mode_sel;
      mode_s2_r <= mode_s1_r;
      sin_s1_r  <= scan_in;
      sin_s2_r  <= sin_s1_r;
    end
  end

  // output enable: reset to the floating level so pins stay off in reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oen_s1_r <= `DP_OEN_IDLE;
      oen_s2_r <= `DP_OEN_IDLE;
    end
    else
    begin
      oen_s1_r <= out_enable_n;
      oen_s2_r <= oen_s1_r;
    end
  end

  // address and pin levels: wide words with no gray code, so the far side
  // must hold them still for a few cycles around each clock edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      adr_s1_r <= '0;
      adr_s2_r <= '0;
      bus_s1_r <= '0;
      bus_s2_r <= '0;
    end
    else
    begin
      adr_s1_r <= prom_address;
      adr_s2_r <= adr_s1_r;
      bus_s1_r <= data_out_bus_in;
      bus_s2_r <= bus_s1_r;
    end
  end

  // rising edges found on the sampled clocks
  wire mclk_rise = mclk_s2_r && !mclk_d_r;
  wire dg_rise   = dg_s2_r && !dg_d_r;
  // a main clock rising edge is only acted on if the buffer can take the word;
  // refusing the load keeps register and stream in step, at the cost
  // of a main clock edge that has no effect while the receiver stalls
  wire load_out  = mclk_rise && buf_ready;

  // output register source select
  wire [DATA_W-1:0] out_nxt = mode_s2_r ? shadow_bits
                                        : rom_word(adr_s2_r);

  // shadow operation decode
  wire diag_prom_pkg::shadow_op_t sh_op =
    !mode_s2_r ? diag_prom_pkg::SH_SHIFT :
    (!sin_s2_r ? diag_prom_pkg::SH_LOAD
               : diag_prom_pkg::SH_HOLD);

  // parallel source: own register when driving, pin levels when floating
  wire [DATA_W-1:0] par_src = oen_s2_r ? bus_s2_r : out_reg_r;
  wire [DATA_W-1:0] shift_v =
    {shadow_bits[DATA_W-2:0], sin_s2_r};

  // output register: changes only on main clock rise, else holds
  always_ff @(posedge clk_sys)
  begin
    if (load_out)
      out_reg_r <= out_nxt;
  end

  // shadow register: independent of the main clock edge
  always_ff @(posedge clk_sys)
  begin
    if (dg_rise)
    begin
      case (sh_op)
        diag_prom_pkg::SH_SHIFT: shadow_bits <= shift_v;
        diag_prom_pkg::SH_LOAD:  shadow_bits <= par_src;
        default:                 shadow_bits <= shadow_bits;
      endcase
    end
  end

  // serial output select
  assign scan_out = mode_s2_r ? sin_s2_r
                              : shadow_bits[DATA_W-1];

  // pin drive: enable low drives, high floats
  assign data_out_bus_out  = out_reg_r;
  assign data_out_bus_oe_n = {DATA_W{oen_s2_r}};

  // every loaded word is offered on the stream side
  word_buffer #(
    .WIDTH (DATA_W),
    .DEPTH (`DP_BUF_DEPTH)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (mclk_rise),
    .in_ready  (buf_ready),
    .in_data   (out_nxt),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );
endmodule : diag_prom

// ### test/diag_prom_asserts.sv
// port checker for the diagnostic prom
`timescale 1ns/10ps
module diag_prom_asserts (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       main_clock,
  input wire logic       diag_clock,
  input wire logic       out_enable_n,
  input wire logic       mode_sel,
  input wire logic       scan_in,
  input wire logic       scan_out,
  input wire logic [3:0] data_out_bus_out,
  input wire logic [3:0] data_out_bus_oe_n,
  input wire logic       word_valid,
  input wire logic       word_ready,
  input wire logic [3:0] word_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_load_on_edge: assert property ($changed(data_out_bus_out) |->
    $past(main_clock, 3) || $past(main_clock, 4)) else $error("bad load");
  a_out_holds: assert property (!main_clock[*8] |->
    $stable(data_out_bus_out)) else $error("output moved");
  a_shadow_holds: assert property ((!mode_sel && !diag_clock)[*8]
    |-> $stable(scan_out)) else $error("shadow moved");
  a_bypass_high: assert property ((mode_sel && scan_in)[*6] |->
    scan_out) else $error("bypass high");
  a_bypass_low: assert property ((mode_sel && !scan_in)[*6] |->
    !scan_out) else $error("bypass low");
  a_pins_float: assert property (out_enable_n[*5] |->
    &data_out_bus_oe_n) else $error("pins driven");
  a_pins_drive: assert property (!out_enable_n[*5] |->
    data_out_bus_oe_n == 4'h0) else $error("pins float");
  a_word_kept: assert property (word_valid && !word_ready |=>
    word_valid && $stable(word_data)) else $error("word lost");
endmodule : diag_prom_asserts
bind diag_prom diag_prom_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .main_clock(main_clock), .diag_clock(diag_clock), .mode_sel(mode_sel),
  .out_enable_n(out_enable_n), .scan_in(scan_in), .scan_out(scan_out),
  .data_out_bus_out(data_out_bus_out), .data_out_bus_oe_n(data_out_bus_oe_n),
  .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));

// ### test/seq_model.sv
// sequencer and scan controller model driving the pin clocks
`timescale 1ns/10ps
module seq_model (
  input  wire logic clk_sys,
  input  wire logic stall,
  output logic      main_clock,
  output logic      diag_clock,
  output logic      word_ready
);
  // a stalled receiver refuses words
  assign word_ready = !stall;
  initial {main_clock, diag_clock} = 2'b00;
  // settle, then one 80 ns cycle; an unchosen clock stays low
  task pulse(input logic [1:0] w);
    repeat (4) @(negedge clk_sys);
    repeat (4) @(negedge clk_sys) {main_clock, diag_clock} = w;
    repeat (4) @(negedge clk_sys) {main_clock, diag_clock} = 2'b00;
  endtask : pulse
endmodule : seq_model

// ### test/tb.sv
// self-checking bench for the diagnostic prom
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
  logic clk_sys = 0, rst_n = 0, mode_sel = 0, scan_in = 0, stall = 0;
  logic out_enable_n = 0;
  logic [11:0] addr = 12'h000;
  logic [3:0] ext = 4'h0, q, oe_n, w_data;
  wire logic main_clock, diag_clock, word_ready, scan_out, w_valid;
  // wire level: each pin from whoever drives it
  wire logic [3:0] bus = (oe_n & ext) | (~oe_n & q);
  int failures = 0, num_checks = 0, cyc = 0;
  typedef struct {logic [11:0] a; logic [3:0] q;} row_t;
  // table word at address a is a[3:0]
  row_t rows [4] = '{'{12'h000, 4'h0}, '{12'h005, 4'h5},
                     '{12'hFFF, 4'hF}, '{12'h7AB, 4'hB}};
  always #5 clk_sys = ~clk_sys;
  seq_model p (.clk_sys(clk_sys), .stall(stall), .main_clock(main_clock),
    .diag_clock(diag_clock), .word_ready(word_ready));
  diag_prom #(.CONTENTS({256{64'hFEDCBA9876543210}})) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .main_clock(main_clock),
    .diag_clock(diag_clock), .mode_sel(mode_sel), .scan_in(scan_in),
    .scan_out(scan_out), .prom_address(addr), .out_enable_n(out_enable_n),
    .data_out_bus_in(bus), .data_out_bus_out(q), .data_out_bus_oe_n(oe_n),
    .word_valid(w_valid), .word_ready(word_ready), .word_data(w_data));
  task finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // set mode, serial input and address, then clock the chosen pins
  task op(input logic m, s, input logic [11:0] a, input logic [1:0] w);
    mode_sel = m;
    scan_in = s;
    addr = a;
    p.pulse(w);
  endtask : op
  // hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      failures++;
      finish_test();
    end
  end
  initial
  begin
    repeat (20) @(negedge clk_sys);
    rst_n = 1;
    repeat (3) @(negedge clk_sys);
    foreach (rows[i])
    begin
      op(0, 0, rows[i].a, 2'b10);
      `CHK(q, rows[i].q)
    end
    `CHK(oe_n, 4'h0)
    for (int i = 3; i >= 0; i--) op(0, i[0], 12'h000, 2'b01);
    `CHK(scan_out, 1'b1)
    `CHK(q, 4'hB)
    op(1, 0, 12'h000, 2'b00);
    `CHK(scan_out, 1'b0)
    op(1, 1, 12'h003, 2'b10);
    `CHK(q, 4'hA)
    op(0, 1, 12'h003, 2'b10);
    op(1, 1, 12'h003, 2'b01);
    op(1, 1, 12'h003, 2'b10);
    `CHK(q, 4'hA)
    op(0, 0, 12'h003, 2'b10);
    op(1, 0, 12'h003, 2'b01);
    op(0, 0, 12'h006, 2'b10);
    op(1, 0, 12'h006, 2'b10);
    `CHK(q, 4'h3)
    out_enable_n = 1;
    ext = 4'h9;
    op(1, 0, 12'h006, 2'b01);
    `CHK(oe_n, 4'hF)
    op(1, 1, 12'h006, 2'b10);
    `CHK(q, 4'h9)
    out_enable_n = 0;
    op(0, 1, 12'h002, 2'b11);
    `CHK(q, 4'h2)
    `CHK(scan_out, 1'b0)
    op(1, 1, 12'h002, 2'b10);
    `CHK(q, 4'h3)
    stall = 1;
    for (int i = 1; i <= 3; i++) op(0, 0, i[11:0], 2'b10);
    `CHK(q, 4'h2)
    `CHK(w_data, 4'h1)
    `CHK(w_valid, 1'b1)
    stall = 0;
    @(negedge clk_sys);
    `CHK(w_data, 4'h2)
    @(negedge clk_sys);
    `CHK(w_valid, 1'b0)
    // mid-run reset: registers keep their words, pins float
    stall = 1;
    op(0, 0, 12'h004, 2'b10);
    rst_n = 0;
    @(negedge clk_sys);
    `CHK(oe_n, 4'hF)
    `CHK(w_valid, 1'b0)
    `CHK(q, 4'h4)
    rst_n = 1;
    repeat (3) @(negedge clk_sys);
    op(0, 0, 12'h005, 2'b10);
    `CHK(q, 4'h5)
    `CHK(w_data, 4'h5)
    stall = 0;
    finish_test();
  end
endmodule : tb
